// >>> hdl/gpc_pkg.sv
// ============================================================
// Constants for the GPIO pin control block
// Summary of operation
// R1: Up to 25 pins over four ports, each programmed alone.
// R2: Per-pin direction, open-drain, drive, pull-up, wake and alternate select registers.
// R3: Alternate-function pins take direction from their peripheral, not the port.
// R4: Two select subregisters per port pick the alternate function.
// R5: Crystal enabled makes port A bits 0 and 1 ignore all GPIO settings; the code still lets their wake bits drive smr_wake.
// R6: Port A bits 0 and 6 carry timer input or complement output per timer mode.
// R7: LED mode makes port C pins current sinks at one of four levels.
// R8: Port D bit 0 is an open-drain reset pin with pull-up until reconfigured.
// R9: Port D bit 0 in GPIO mode is output only; the logic forces it so, whatever its direction bit.
// R10: Port D bit 0 has high drive but no stop-mode wake.
// R11: Implemented pins follow package and converter option bits.
// R12: Port B alternate choice uses both select bits, as other ports do, with alternate enable set.
// R13: Pin inputs pass two synchroniser stages before any use.
// Assumes one 100 MHz clock, asynchronous active-high reset, AXI4-Lite host.
package gpc_pkg;
  // ============================================================
  // Register map: port p sub s at p*0x40 + s*4, globals from 0x100
  localparam logic [8:0] PORT_STRIDE = 9'h040;
  localparam logic [3:0] SUB_OUT = 4'h0;
  localparam logic [3:0] SUB_DIR = 4'h1;
  localparam logic [3:0] SUB_AFEN = 4'h2;
  localparam logic [3:0] SUB_AFSLO = 4'h3;
  localparam logic [3:0] SUB_AFSHI = 4'h4;
  localparam logic [3:0] SUB_OD = 4'h5;
  localparam logic [3:0] SUB_HDR = 4'h6;
  localparam logic [3:0] SUB_PU = 4'h7;
  localparam logic [3:0] SUB_SMR = 4'h8;
  localparam logic [3:0] SUB_IN = 4'h9;
  localparam int NUM_SUB_RW = 9;
  localparam logic [8:0] ADDR_LED_EN = 9'h100;
  localparam logic [8:0] ADDR_LED_LVL = 9'h104;
  localparam logic [8:0] ADDR_CTRL = 9'h108;
  // ============================================================
  // Field positions and reset values
  localparam int CTRL_RSTPIN_BIT = 0;
  localparam int CTRL_PKG28_BIT = 1;
  localparam int CTRL_ADC_BIT = 2;
  localparam logic [7:0] RST_DIR = 8'hff;
  localparam logic [7:0] RST_OTHER = 8'h00;
  localparam logic [15:0] RST_LED_LVL = 16'h0000;
  localparam logic RST_RSTPIN_MODE = 1'b1;
  // Pin indices within the 32-bit pin vector
  localparam int PORT_A = 0;
  localparam int PORT_B = 1;
  localparam int PORT_C = 2;
  localparam int PORT_D = 3;
  localparam int PIN_A0 = 0;
  localparam int PIN_A1 = 1;
  localparam int PIN_A6 = 6;
  localparam int PIN_D0 = 24;
  // Implemented pins per package and converter option
  localparam logic [7:0] MASK_B_20 = 8'h0f;
  localparam logic [7:0] MASK_B_28_ADC = 8'h3f;
  localparam logic [7:0] MASK_B_28 = 8'hff;
  localparam logic [7:0] MASK_C_20 = 8'h0f;
  localparam logic [7:0] MASK_C_28 = 8'hff;
  localparam logic [7:0] MASK_D = 8'h01;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// >>> hdl/gpc_pin_control.sv
// ============================================================
// GPIO pin control: registers over AXI4-Lite and per-pin drive logic
// Pins are split into input, output and active-low output enable;
// the board model resolves pads, pull-ups and outside drivers.
//
// The address map and the AXI4-Lite interface to the registers were chosen for this implementation.
module gpc_pin_control (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic [8:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [8:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  input wire logic opt_pkg28,
  input wire logic opt_adc_en,
  input wire logic xtal_en,
  input wire logic tmr0_cmp_mode,
  input wire logic tmr1_cmp_mode,
  input wire logic rst_drive_low,
  input wire logic [31:0] af_out,
  input wire logic [31:0] af_drive,
  input wire logic [31:0] pin_in,
  output logic [31:0] pin_out,
  output logic [31:0] pin_oe_n,
  output logic [31:0] pin_pullup,
  output logic [31:0] pin_high_drive,
  output logic [7:0] led_sink_en,
  output logic [15:0] led_level,
  output logic [31:0] af_sel_low,
  output logic [31:0] af_sel_high,
  output logic [31:0] periph_in,
  output logic reset_pin_level,
  output logic smr_wake,
  output logic xtal_pins_taken
);
  // ============================================================
  // Register state
  // R2: per-port control
  logic [7:0] cfg_r [0:3][0:8];
  logic [7:0] cfg_nxt [0:3][0:8];
  logic [7:0] led_en_r, led_en_nxt;
  logic [15:0] led_lvl_r, led_lvl_nxt;
  logic rstpin_mode_r, rstpin_mode_nxt;
  logic aw_full_r, aw_full_nxt;
  logic w_full_r, w_full_nxt;
  logic [8:0] awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic awready_r, awready_nxt;
  logic wready_r, wready_nxt;
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic arready_r, arready_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0] rresp_r, rresp_nxt;
  // ============================================================
  // Synchronisers and pin state
  logic [31:0] sync1_r, sync2_r, prev_r;
  logic [1:0] opt_s1_r, opt_s2_r;
  logic [31:0] pin_out_r, pin_out_nxt;
  logic [31:0] pin_oe_n_r, pin_oe_n_nxt;
  logic [31:0] pu_r, pu_nxt;
  logic [31:0] hd_r, hd_nxt;
  logic [31:0] periph_r, periph_nxt;
  logic [31:0] afl_r, afl_nxt;
  logic [31:0] afh_r, afh_nxt;
  logic [7:0] led_sink_r, led_sink_nxt;
  logic [15:0] led_level_r;
  logic rst_lvl_r, rst_lvl_nxt;
  logic wake_r, wake_nxt;
  logic xtal_r;
  logic [31:0] impl_mask;
  logic [31:0] wake_en;
  logic [31:0] v_out, v_dir, v_afen, v_afslo, v_afshi, v_od, v_hdr, v_pu, v_smr;

  // Flatten per-port registers into 32-bit pin vectors
  always_comb begin
    for (int p = 0; p < 4; p++) begin
      v_out[p*8 +: 8] = cfg_r[p][gpc_pkg::SUB_OUT];
      v_dir[p*8 +: 8] = cfg_r[p][gpc_pkg::SUB_DIR];
      v_afen[p*8 +: 8] = cfg_r[p][gpc_pkg::SUB_AFEN];
      v_afslo[p*8 +: 8] = cfg_r[p][gpc_pkg::SUB_AFSLO];
      v_afshi[p*8 +: 8] = cfg_r[p][gpc_pkg::SUB_AFSHI];
      v_od[p*8 +: 8] = cfg_r[p][gpc_pkg::SUB_OD];
      v_hdr[p*8 +: 8] = cfg_r[p][gpc_pkg::SUB_HDR];
      v_pu[p*8 +: 8] = cfg_r[p][gpc_pkg::SUB_PU];
      v_smr[p*8 +: 8] = cfg_r[p][gpc_pkg::SUB_SMR];
    end
  end

  // R11: implemented pins from option bits
  always_comb begin
    impl_mask[7:0] = 8'hff;
    if (!opt_s2_r[0]) begin
      impl_mask[15:8] = gpc_pkg::MASK_B_20;
      impl_mask[23:16] = gpc_pkg::MASK_C_20;
    end else begin
      impl_mask[15:8] = opt_s2_r[1] ? gpc_pkg::MASK_B_28_ADC : gpc_pkg::MASK_B_28;
      impl_mask[23:16] = gpc_pkg::MASK_C_28;
    end
    impl_mask[31:24] = gpc_pkg::MASK_D;
  end

  // ============================================================
  // AXI4-Lite slave and register writes
  always_comb begin
    logic [8:0] wa;
    logic [8:0] ra;
    logic [1:0] wp;
    logic [3:0] ws;
    wa = awaddr_r;
    ra = s_araddr;
    wp = 2'h0;
    ws = 4'h0;
    cfg_nxt = cfg_r;
    led_en_nxt = led_en_r;
    led_lvl_nxt = led_lvl_r;
    rstpin_mode_nxt = rstpin_mode_r;
    aw_full_nxt = aw_full_r;
    w_full_nxt = w_full_r;
    awaddr_nxt = awaddr_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (s_awvalid && awready_r) begin
      aw_full_nxt = 1'b1;
      awaddr_nxt = s_awaddr;
    end
    if (s_wvalid && wready_r) begin
      w_full_nxt = 1'b1;
      wdata_nxt = s_wdata;
      wstrb_nxt = s_wstrb;
    end
    if (bvalid_r && s_bready) begin
      bvalid_nxt = 1'b0;
    end
    if (aw_full_nxt && w_full_nxt && !bvalid_nxt) begin
      wa = awaddr_nxt;
      wp = wa[7:6];
      ws = wa[5:2];
      aw_full_nxt = 1'b0;
      w_full_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = gpc_pkg::RESP_OKAY;
      if (!wa[8] && ws < 4'(gpc_pkg::NUM_SUB_RW)) begin
        // R1: one write sets all eight pin bits of the port register together
        if (wstrb_nxt[0]) begin
          cfg_nxt[wp][ws] = wdata_nxt[7:0];
        end
      end else if (!wa[8] && ws == gpc_pkg::SUB_IN) begin
        bresp_nxt = gpc_pkg::RESP_OKAY;
      end else if ({wa[8:2], 2'b00} == gpc_pkg::ADDR_LED_EN) begin
        if (wstrb_nxt[0]) begin
          led_en_nxt = wdata_nxt[7:0];
        end
      end else if ({wa[8:2], 2'b00} == gpc_pkg::ADDR_LED_LVL) begin
        if (wstrb_nxt[0]) begin
          led_lvl_nxt[7:0] = wdata_nxt[7:0];
        end
        if (wstrb_nxt[1]) begin
          led_lvl_nxt[15:8] = wdata_nxt[15:8];
        end
      end else if ({wa[8:2], 2'b00} == gpc_pkg::ADDR_CTRL) begin
        // R8: software releases the reset pin to GPIO
        if (wstrb_nxt[0]) begin
          rstpin_mode_nxt = wdata_nxt[gpc_pkg::CTRL_RSTPIN_BIT];
        end
      end else begin
        bresp_nxt = gpc_pkg::RESP_SLVERR;
      end
    end
    awready_nxt = !aw_full_nxt && !bvalid_nxt;
    wready_nxt = !w_full_nxt && !bvalid_nxt;
    if (rvalid_r && s_rready) begin
      rvalid_nxt = 1'b0;
    end
    if (s_arvalid && arready_r) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = gpc_pkg::RESP_OKAY;
      rdata_nxt = 32'h0000_0000;
      if (!ra[8] && ra[5:2] < 4'(gpc_pkg::NUM_SUB_RW)) begin
        rdata_nxt[7:0] = cfg_r[ra[7:6]][ra[5:2]];
      end else if (!ra[8] && ra[5:2] == gpc_pkg::SUB_IN) begin
        rdata_nxt[7:0] = periph_r[ra[7:6]*8 +: 8];
      end else if ({ra[8:2], 2'b00} == gpc_pkg::ADDR_LED_EN) begin
        rdata_nxt[7:0] = led_en_r;
      end else if ({ra[8:2], 2'b00} == gpc_pkg::ADDR_LED_LVL) begin
        rdata_nxt[15:0] = led_lvl_r;
      end else if ({ra[8:2], 2'b00} == gpc_pkg::ADDR_CTRL) begin
        rdata_nxt[gpc_pkg::CTRL_RSTPIN_BIT] = rstpin_mode_r;
        rdata_nxt[gpc_pkg::CTRL_PKG28_BIT] = opt_s2_r[0];
        rdata_nxt[gpc_pkg::CTRL_ADC_BIT] = opt_s2_r[1];
      end else begin
        rresp_nxt = gpc_pkg::RESP_SLVERR;
      end
    end
    arready_nxt = !rvalid_nxt;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      for (int p = 0; p < 4; p++) begin
        for (int s = 0; s < gpc_pkg::NUM_SUB_RW; s++) begin
          cfg_r[p][s] <= (s == int'(gpc_pkg::SUB_DIR)) ? gpc_pkg::RST_DIR : gpc_pkg::RST_OTHER;
        end
      end
      led_en_r <= gpc_pkg::RST_OTHER;
      led_lvl_r <= gpc_pkg::RST_LED_LVL;
      rstpin_mode_r <= gpc_pkg::RST_RSTPIN_MODE;
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      awaddr_r <= 9'h000;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= 2'h0;
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= 2'h0;
    end else if (ce) begin
      cfg_r <= cfg_nxt;
      led_en_r <= led_en_nxt;
      led_lvl_r <= led_lvl_nxt;
      rstpin_mode_r <= rstpin_mode_nxt;
      aw_full_r <= aw_full_nxt;
      w_full_r <= w_full_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end

  // ============================================================
  // Per-pin drive logic
  // R10: the reset pin never wakes the part
  assign wake_en = v_smr & impl_mask & ~(32'h1 << gpc_pkg::PIN_D0);

  genvar g;
  generate
    for (g = 0; g < 32; g++) begin : g_pin
      logic drive, val, alt;
      // R3: alternate function owns direction
      // R12: port B needs alternate enable as well as its select bits
      assign alt = v_afen[g];
      always_comb begin
        // R6: timer mode chooses input or complement output
        if (alt && g == gpc_pkg::PIN_A0) begin
          drive = tmr0_cmp_mode;
        end else if (alt && g == gpc_pkg::PIN_A6) begin
          drive = tmr1_cmp_mode;
        end else if (alt) begin
          drive = af_drive[g];
        end else if (g == gpc_pkg::PIN_D0) begin
          // R9: GPIO reset pin is output only
          drive = 1'b1;
        end else begin
          drive = !v_dir[g];
        end
        val = alt ? af_out[g] : v_out[g];
        pin_out_nxt[g] = val;
        pin_oe_n_nxt[g] = !(drive && (!v_od[g] || !val));
        pu_nxt[g] = v_pu[g];
        hd_nxt[g] = v_hdr[g];
        // R4: select bits out
        afl_nxt[g] = alt && v_afslo[g];
        afh_nxt[g] = alt && v_afshi[g];
        // R5: crystal takes port A bits 0 and 1
        if (xtal_en && (g == gpc_pkg::PIN_A0 || g == gpc_pkg::PIN_A1)) begin
          pin_oe_n_nxt[g] = 1'b1;
          pu_nxt[g] = 1'b0;
          hd_nxt[g] = 1'b0;
          afl_nxt[g] = 1'b0;
          afh_nxt[g] = 1'b0;
        end
        // R8: open-drain reset with pull-up
        if (g == gpc_pkg::PIN_D0 && rstpin_mode_r) begin
          pin_out_nxt[g] = 1'b0;
          pin_oe_n_nxt[g] = !rst_drive_low;
          pu_nxt[g] = 1'b1;
          afl_nxt[g] = 1'b0;
          afh_nxt[g] = 1'b0;
        end
        // R11: absent pins are never driven
        if (!impl_mask[g]) begin
          pin_oe_n_nxt[g] = 1'b1;
          pu_nxt[g] = 1'b0;
          hd_nxt[g] = 1'b0;
        end
        periph_nxt[g] = sync2_r[g] && impl_mask[g];
      end
    end
  endgenerate

  // R7: port C LED sink and four-level strength
  always_comb begin
    led_sink_nxt = led_en_r & impl_mask[23:16];
    wake_nxt = |((sync2_r ^ prev_r) & wake_en);
    rst_lvl_nxt = sync2_r[gpc_pkg::PIN_D0];
  end

  // R13: two-stage input synchroniser
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sync1_r <= 32'h0000_0000;
      sync2_r <= 32'h0000_0000;
      prev_r <= 32'h0000_0000;
      opt_s1_r <= 2'h0;
      opt_s2_r <= 2'h0;
      pin_out_r <= 32'h0000_0000;
      pin_oe_n_r <= 32'hffff_ffff;
      pu_r <= 32'h0000_0000;
      hd_r <= 32'h0000_0000;
      periph_r <= 32'h0000_0000;
      afl_r <= 32'h0000_0000;
      afh_r <= 32'h0000_0000;
      led_sink_r <= 8'h00;
      led_level_r <= 16'h0000;
      rst_lvl_r <= 1'b1;
      wake_r <= 1'b0;
      xtal_r <= 1'b0;
    end else if (ce) begin
      sync1_r <= pin_in;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
      opt_s1_r <= {opt_adc_en, opt_pkg28};
      opt_s2_r <= opt_s1_r;
      pin_out_r <= pin_out_nxt;
      pin_oe_n_r <= pin_oe_n_nxt;
      pu_r <= pu_nxt;
      hd_r <= hd_nxt;
      periph_r <= periph_nxt;
      afl_r <= afl_nxt;
      afh_r <= afh_nxt;
      led_sink_r <= led_sink_nxt;
      led_level_r <= led_lvl_r;
      rst_lvl_r <= rst_lvl_nxt;
      wake_r <= wake_nxt;
      xtal_r <= xtal_en;
    end
  end

  assign s_awready = awready_r;
  assign s_wready = wready_r;
  assign s_bvalid = bvalid_r;
  assign s_bresp = bresp_r;
  assign s_arready = arready_r;
  assign s_rvalid = rvalid_r;
  assign s_rdata = rdata_r;
  assign s_rresp = rresp_r;
  assign pin_out = pin_out_r;
  assign pin_oe_n = pin_oe_n_r;
  assign pin_pullup = pu_r;
  assign pin_high_drive = hd_r;
  assign led_sink_en = led_sink_r;
  assign led_level = led_level_r;
  assign af_sel_low = afl_r;
  assign af_sel_high = afh_r;
  assign periph_in = periph_r;
  assign reset_pin_level = rst_lvl_r;
  assign smr_wake = wake_r;
  assign xtal_pins_taken = xtal_r;
endmodule

// >>> tb/gpc_pin_control_asserts.sv
// Concurrent checks on the pin control block ports
// Assumes pads stay steady while ce is low; bound to every instance
module gpc_pin_control_asserts (
  input wire logic clk,
  input wire logic reset,
  input wire logic opt_pkg28,
  input wire logic opt_adc_en,
  input wire logic xtal_pins_taken,
  input wire logic smr_wake,
  input wire logic reset_pin_level,
  input wire logic [31:0] pin_in,
  input wire logic [31:0] pin_oe_n,
  input wire logic [31:0] pin_pullup,
  input wire logic [31:0] periph_in,
  input wire logic s_bvalid,
  input wire logic s_bready,
  input wire logic [1:0] s_bresp,
  input wire logic s_rvalid,
  input wire logic s_rready,
  input wire logic [31:0] s_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  // ============================================================
  // Edges since reset; the input history is only real after three
  logic [1:0] live_r;
  logic [1:0] live_nxt;
  always_comb begin
    live_nxt = (live_r == 2'h3) ? live_r : live_r + 2'h1;
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      live_r <= 2'h0;
    end else begin
      live_r <= live_nxt;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // ============================================================
  // Properties
  property p_xtal_release;
    xtal_pins_taken && $past(xtal_pins_taken) |-> pin_oe_n[1:0] == 2'h3 && pin_pullup[1:0] == 2'h0;
  endproperty
  a_xtal_release: assert property (p_xtal_release)
    else $error("crystal pins still driven");
  property p_sync_a;
    live_r == 2'h3 |-> periph_in[7:2] == $past(pin_in[7:2], 3);
  endproperty
  a_sync_a: assert property (p_sync_a)
    else $error("port a input depth wrong");
  property p_sync_d0;
    live_r == 2'h3 |-> reset_pin_level == $past(pin_in[24], 3);
  endproperty
  a_sync_d0: assert property (p_sync_d0)
    else $error("reset pin level depth wrong");
  property p_d0_boot;
    $past(reset) |=> pin_pullup[24];
  endproperty
  a_d0_boot: assert property (p_d0_boot)
    else $error("reset pin pull-up missing");
  property p_upper_absent;
    pin_oe_n[31:25] == 7'h7f && periph_in[31:25] == 7'h00 && pin_pullup[31:25] == 7'h00;
  endproperty
  a_upper_absent: assert property (p_upper_absent)
    else $error("absent pin active");
  property p_pkg20;
    (!opt_pkg28) [*4] |-> pin_oe_n[15:12] == 4'hf && pin_oe_n[23:20] == 4'hf
      && periph_in[23:20] == 4'h0;
  endproperty
  a_pkg20: assert property (p_pkg20)
    else $error("small package pin active");
  property p_adc28;
    (opt_pkg28 && opt_adc_en) [*4] |-> pin_oe_n[15:14] == 2'h3 && periph_in[15:14] == 2'h0;
  endproperty
  a_adc28: assert property (p_adc28)
    else $error("converter package pin active");
  property p_bhold;
    s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp);
  endproperty
  a_bhold: assert property (p_bhold)
    else $error("write response dropped");
  property p_rhold;
    s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata);
  endproperty
  a_rhold: assert property (p_rhold)
    else $error("read data dropped");
  c_wake: cover property (smr_wake);
  c_xtal: cover property (xtal_pins_taken);
  c_slverr: cover property (s_bvalid && s_bready && s_bresp == 2'h2);
endmodule

bind gpc_pin_control gpc_pin_control_asserts chk_u (.clk, .reset, .opt_pkg28, .opt_adc_en,
  .xtal_pins_taken, .smr_wake, .reset_pin_level, .pin_in, .pin_oe_n, .pin_pullup, .periph_in,
  .s_bvalid, .s_bready, .s_bresp, .s_rvalid, .s_rready, .s_rdata);

// >>> tb/gpc_board_model.sv
// Board model: resolves each pad from the block drive and outside drivers
// Assumes an outside driver never fights a pin the block drives
module gpc_board_model (
  input wire logic clk,
  input wire logic [31:0] pin_out,
  input wire logic [31:0] pin_oe_n,
  input wire logic [31:0] pin_pullup,
  input wire logic [31:0] ext_en,
  input wire logic [31:0] ext_val,
  output logic [31:0] pad
);
  timeunit 1ns;
  timeprecision 1ns;
  // Undriven pads wander, so a missing pull-up cannot hide
  logic [31:0] float_r = 32'h5555aaaa;
  always @(posedge clk) begin
    float_r <= ~float_r;
  end
  always_comb begin
    for (int i = 0; i < 32; i++) begin
      if (!pin_oe_n[i]) pad[i] = pin_out[i];
      else if (ext_en[i]) pad[i] = ext_val[i];
      else if (pin_pullup[i]) pad[i] = 1'b1;
      else pad[i] = float_r[i];
    end
  end
endmodule

// >>> tb/gpio_pin_control_tb.sv
// Self-checking bench for the pin control block
// Drives AXI4-Lite by hand; board model resolves the pads
module gpio_pin_control_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, reset = 1'b1, ce = 1'b1, opt_pkg28 = 1'b0, opt_adc_en = 1'b0;
  logic xtal_en = 1'b0, tmr0_cmp_mode = 1'b0, tmr1_cmp_mode = 1'b0, rst_drive_low = 1'b0;
  logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0, s_rready = 1'b0;
  logic [8:0] s_awaddr = 9'h0, s_araddr = 9'h0;
  logic [3:0] s_wstrb = 4'hf;
  logic [31:0] s_wdata = 32'h0, af_out = 32'h0, af_drive = 32'h0, ext_en = 32'h0, ext_val = 32'h0;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, reset_pin_level, smr_wake;
  logic xtal_pins_taken;
  logic [1:0] s_bresp, s_rresp;
  logic [7:0] led_sink_en;
  logic [15:0] led_level;
  logic [31:0] s_rdata, pin_in, pin_out, pin_oe_n, pin_pullup, pin_high_drive, af_sel_low;
  logic [31:0] af_sel_high, periph_in;
  int mismatches = 0, checks = 0, cycles = 0, wakes = 0, w = 0;
  gpc_pin_control dut_u (.clk, .reset, .ce, .s_awaddr, .s_awvalid, .s_awready, .s_wdata,
    .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid,
    .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready, .opt_pkg28, .opt_adc_en, .xtal_en,
    .tmr0_cmp_mode, .tmr1_cmp_mode, .rst_drive_low, .af_out, .af_drive, .pin_in, .pin_out,
    .pin_oe_n, .pin_pullup, .pin_high_drive, .led_sink_en, .led_level, .af_sel_low,
    .af_sel_high, .periph_in, .reset_pin_level, .smr_wake, .xtal_pins_taken);
  gpc_board_model brd_u (.clk, .pin_out, .pin_oe_n, .pin_pullup, .ext_en, .ext_val,
    .pad(pin_in));
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (smr_wake === 1'b1) wakes <= wakes + 1;
    if (cycles == 5000) begin
      mismatches++;
      end_sim();
    end
  end
  // ============================================================
  // Common tasks
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  function automatic logic [8:0] ad(input int p, input logic [3:0] s);
    return 9'(p) * gpc_pkg::PORT_STRIDE + {3'h0, s, 2'h0};
  endfunction
  task automatic wr(input logic [8:0] a, input logic [31:0] d, input logic [1:0] e = 2'h0);
    logic aw;
    logic wd;
    aw = 1'b0;
    wd = 1'b0;
    s_awaddr <= a;
    s_awvalid <= 1'b1;
    s_wdata <= d;
    s_wvalid <= 1'b1;
    while (!(aw && wd)) begin
      @(posedge clk);
      if (s_awvalid && s_awready) begin
        aw = 1'b1;
        s_awvalid <= 1'b0;
      end
      if (s_wvalid && s_wready) begin
        wd = 1'b1;
        s_wvalid <= 1'b0;
      end
    end
    while (!s_bvalid) @(posedge clk);
    s_bready <= 1'b1;
    @(posedge clk);
    s_bready <= 1'b0;
    chk("bresp", 32'(e), 32'(s_bresp));
  endtask
  task automatic rdchk(input logic [8:0] a, input logic [31:0] e, input string n,
      input logic [1:0] er = 2'h0);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    do @(posedge clk); while (!(s_arvalid && s_arready));
    s_arvalid <= 1'b0;
    do @(posedge clk); while (!s_rvalid);
    s_rready <= 1'b1;
    @(posedge clk);
    s_rready <= 1'b0;
    chk("rresp", 32'(er), 32'(s_rresp));
    if (er == gpc_pkg::RESP_OKAY) chk(n, e, s_rdata);
  endtask
  // ============================================================
  // Scenarios
  task automatic t_reset();
    chk("d0_boot", 32'h3, {30'h0, pin_pullup[24], pin_oe_n[24]});
    rdchk(gpc_pkg::ADDR_CTRL, 32'h1, "ctrl_reset");
    rdchk(ad(0, gpc_pkg::SUB_DIR), 32'hff, "dir_reset");
    wr(9'h1fc, 32'h0, gpc_pkg::RESP_SLVERR);
    rdchk(9'h1fc, 32'h0, "unmapped", gpc_pkg::RESP_SLVERR);
    $display("test reset done");
  endtask
  task automatic t_port_a();
    wr(ad(0, gpc_pkg::SUB_DIR), 32'h0);
    wr(ad(0, gpc_pkg::SUB_OUT), 32'ha5);
    wr(ad(0, gpc_pkg::SUB_OD), 32'h81);
    wr(ad(0, gpc_pkg::SUB_PU), 32'h3c);
    wr(ad(0, gpc_pkg::SUB_HDR), 32'hc3);
    chk("a_out", 32'ha5, 32'(pin_out[7:0]));
    chk("a_oe", 32'h81, 32'(pin_oe_n[7:0]));
    chk("a_pu_hd", 32'h3cc3, {16'h0, pin_pullup[7:0], pin_high_drive[7:0]});
    wr(ad(0, gpc_pkg::SUB_OD), 32'h0);
    wr(ad(0, gpc_pkg::SUB_DIR), 32'h04);
    af_out <= 32'h4;
    af_drive <= 32'h4;
    wr(ad(0, gpc_pkg::SUB_AFEN), 32'h04);
    chk("a_alt_drive", 32'h0, 32'(pin_oe_n[7:0]));
    af_drive <= 32'h0;
    repeat (3) @(posedge clk);
    chk("a_alt_release", 32'h04, 32'(pin_oe_n[7:0]));
    $display("test port_a done");
  endtask
  task automatic t_wake();
    ext_en <= 32'h8;
    wr(ad(0, gpc_pkg::SUB_DIR), 32'h08);
    wr(ad(0, gpc_pkg::SUB_SMR), 32'h08);
    repeat (6) @(posedge clk);
    w = wakes;
    ext_val <= 32'h8;
    repeat (6) @(posedge clk);
    chk("wake_count", 32'h1, 32'(wakes - w));
    rdchk(ad(0, gpc_pkg::SUB_IN), 32'had, "a_input");
    wr(ad(0, gpc_pkg::SUB_IN), 32'h0);
    rdchk(ad(0, gpc_pkg::SUB_IN), 32'had, "a_input_ro");
    $display("test wake done");
  endtask
  task automatic t_pkg();
    wr(ad(1, gpc_pkg::SUB_DIR), 32'h0);
    wr(ad(1, gpc_pkg::SUB_OUT), 32'hff);
    wr(ad(2, gpc_pkg::SUB_DIR), 32'h0);
    chk("bc_20", 32'hf0f0, {16'h0, pin_oe_n[23:16], pin_oe_n[15:8]});
    opt_pkg28 <= 1'b1;
    opt_adc_en <= 1'b1;
    repeat (4) @(posedge clk);
    chk("b_28_adc", 32'hc0, 32'(pin_oe_n[15:8]));
    rdchk(gpc_pkg::ADDR_CTRL, 32'h7, "ctrl_opts");
    opt_adc_en <= 1'b0;
    repeat (4) @(posedge clk);
    chk("bc_28", 32'h0, {16'h0, pin_oe_n[23:16], pin_oe_n[15:8]});
    $display("test package done");
  endtask
  task automatic t_alt_mix();
    wr(ad(1, gpc_pkg::SUB_AFSLO), 32'h03);
    wr(ad(1, gpc_pkg::SUB_AFSHI), 32'h03);
    wr(ad(1, gpc_pkg::SUB_AFEN), 32'h01);
    chk("b_sel", 32'h0101, {16'h0, af_sel_high[15:8], af_sel_low[15:8]});
    wr(ad(0, gpc_pkg::SUB_PU), 32'hff);
    xtal_en <= 1'b1;
    repeat (3) @(posedge clk);
    chk("xtal_on", 32'h1c, {27'h0, xtal_pins_taken, pin_oe_n[1:0], pin_pullup[1:0]});
    xtal_en <= 1'b0;
    repeat (3) @(posedge clk);
    chk("xtal_off", 32'h03, {27'h0, xtal_pins_taken, pin_oe_n[1:0], pin_pullup[1:0]});
    wr(ad(0, gpc_pkg::SUB_AFEN), 32'h41);
    tmr0_cmp_mode <= 1'b1;
    tmr1_cmp_mode <= 1'b1;
    repeat (3) @(posedge clk);
    chk("tmr_out", 32'h0, {30'h0, pin_oe_n[6], pin_oe_n[0]});
    tmr0_cmp_mode <= 1'b0;
    tmr1_cmp_mode <= 1'b0;
    repeat (3) @(posedge clk);
    chk("tmr_in", 32'h3, {30'h0, pin_oe_n[6], pin_oe_n[0]});
    $display("test alternate done");
  endtask
  task automatic t_d0();
    rst_drive_low <= 1'b1;
    repeat (6) @(posedge clk);
    chk("d0_low", 32'h0, {29'h0, pin_oe_n[24], pin_out[24], reset_pin_level});
    rst_drive_low <= 1'b0;
    repeat (6) @(posedge clk);
    chk("d0_release", 32'h3, {30'h0, pin_oe_n[24], reset_pin_level});
    w = wakes;
    wr(gpc_pkg::ADDR_CTRL, 32'h0);
    wr(ad(3, gpc_pkg::SUB_DIR), 32'h0);
    wr(ad(3, gpc_pkg::SUB_SMR), 32'h1);
    wr(ad(3, gpc_pkg::SUB_HDR), 32'h1);
    wr(ad(3, gpc_pkg::SUB_OUT), 32'h1);
    chk("d0_gpio", 32'h3, {29'h0, pin_oe_n[24], pin_high_drive[24], pin_out[24]});
    wr(ad(3, gpc_pkg::SUB_OUT), 32'h0);
    repeat (6) @(posedge clk);
    chk("d0_no_wake", 32'h0, 32'(wakes - w));
    $display("test d0 done");
  endtask
  task automatic t_led();
    wr(gpc_pkg::ADDR_LED_EN, 32'h81);
    chk("led_en", 32'h81, 32'(led_sink_en));
    for (int k = 0; k < 4; k++) begin
      wr(gpc_pkg::ADDR_LED_LVL, 32'(k * 16'h4001));
      chk("led_level", 32'(k * 16'h4001), 32'(led_level));
    end
    ce <= 1'b0;
    xtal_en <= 1'b1;
    repeat (3) @(posedge clk);
    chk("ce_freeze", 32'h0, 32'(xtal_pins_taken));
    ce <= 1'b1;
    xtal_en <= 1'b0;
    $display("test led done");
  endtask
  initial begin
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    repeat (2) @(posedge clk);
    t_reset();
    t_port_a();
    t_wake();
    t_pkg();
    t_alt_mix();
    t_d0();
    t_led();
    end_sim();
  end
endmodule
